/* File: src/sqcn_pkg.sv */
// Constants and types shared by the split queue completion notifier.
`default_nettype none
package sqcn_pkg;
    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int IDX_W  = 16;
    localparam int BE_W   = 4;
    // ----------------------------------------------------------------
    // Register map, byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL        = 8'h00;
    localparam logic [7:0] REG_USED_BASE   = 8'h04;
    localparam logic [7:0] REG_AVAIL_BASE  = 8'h08;
    localparam logic [7:0] REG_QSIZE       = 8'h0C;
    localparam logic [7:0] REG_KICK_THRESH = 8'h10;
    localparam logic [7:0] REG_STATUS      = 8'h14;
    localparam logic [7:0] REG_NOTIFY_CNT  = 8'h18;
    localparam logic [7:0] REG_KICK_CNT    = 8'h1C;
    // ----------------------------------------------------------------
    // Control and status fields
    // ----------------------------------------------------------------
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_EVT_BIT    = 1;
    localparam int CTRL_INORD_BIT  = 2;
    localparam int CTRL_NOKICK_BIT = 3;
    localparam int CTRL_W          = 4;
    localparam int STAT_BUSY_BIT   = 16;
    localparam logic [CTRL_W-1:0] CTRL_RST  = 4'h0;
    localparam logic [IDX_W-1:0]  QSIZE_RST = 16'h0100;
    // ----------------------------------------------------------------
    // Ring layout, byte offsets within a ring
    // ----------------------------------------------------------------
    localparam int RING_OFS       = 4;
    localparam int USED_ELEM_SH   = 3;
    localparam int USED_LEN_OFS   = 4;
    localparam int AVAIL_ENT_SH   = 1;
    localparam logic [15:0] FLAG_NO_NOTIFY = 16'h0001;
    localparam logic [BE_W-1:0] BE_WORD = 4'hF;
    localparam logic [BE_W-1:0] BE_LOW  = 4'h3;
    // ----------------------------------------------------------------
    // Engine states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_HEAD, ST_LEN, ST_KTHR, ST_IDX, ST_FLAGS, ST_UEVT,
        ST_DECIDE
    } sqcn_state_type;
endpackage
`default_nettype wire

/* File: src/sqcn_mem_if.sv */
// Request and answer bundle between the engine and its memory port.
`default_nettype none
interface sqcn_mem_if #(parameter int ADDR_W = 32);
    import sqcn_pkg::*;
    logic              start;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0]   be;
    logic              done;
    logic [DATA_W-1:0] rdata;
    modport engine (output start, we, addr, wdata, be,
                    input  done, rdata);
    modport port   (input  start, we, addr, wdata, be,
                    output done, rdata);
endinterface
`default_nettype wire

/* File: src/sqcn_mem_port.sv */
// Single-outstanding memory master that serves one engine request.
`default_nettype none
module sqcn_mem_port
    import sqcn_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Engine side
    sqcn_mem_if.port               req,
    // Memory bus
    output logic                   mem_req,
    output logic                   mem_we,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [DATA_W-1:0]      mem_wdata,
    output logic [BE_W-1:0]        mem_be,
    input  wire logic              mem_gnt,
    input  wire logic              mem_rvalid,
    input  wire logic [DATA_W-1:0] mem_rdata
);
    typedef struct packed {
        logic              req;
        logic              wait_rd;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [BE_W-1:0]   be;
        logic              done;
        logic [DATA_W-1:0] rdata;
    } sqcn_port_type;

    sqcn_port_type s_r;
    sqcn_port_type s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        if (req.start) begin
            s_nxt.req   = 1'b1;
            s_nxt.we    = req.we;
            s_nxt.addr  = req.addr;
            s_nxt.wdata = req.wdata;
            s_nxt.be    = req.be;
        end else if (s_r.req && mem_gnt) begin
            s_nxt.req     = 1'b0;
            // A write counts as visible once the bus has granted it.
            s_nxt.done    = s_r.we;
            s_nxt.wait_rd = !s_r.we;
        end else if (s_r.wait_rd && mem_rvalid) begin
            s_nxt.wait_rd = 1'b0;
            s_nxt.done    = 1'b1;
            s_nxt.rdata   = mem_rdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign mem_req   = s_r.req;
    assign mem_we    = s_r.we;
    assign mem_addr  = s_r.addr;
    assign mem_wdata = s_r.wdata;
    assign mem_be    = s_r.be;
    assign req.done  = s_r.done;
    assign req.rdata = s_r.rdata;
endmodule
`default_nettype wire

/* File: src/sqcn_top.sv */
// Split queue used-ring writer with notification decisions.
// Function
// - No event index: notify when driver flags zero.
// - No event index: ignore driver completion threshold.
// - Event index: ignore low bit of driver flags.
// - Event index: notify when used index moves past threshold.
// - Device tolerates unwanted kicks from the driver.
// - Used ring: flags, index, elements, kick threshold.
// - Element carries chain head and bytes written.
// - Used index starts at zero, only increases.
// - Byte count stored before the index advances.
// - Data written before the used index advances.
// - Device may write more than it reports.
// - In order: one element, index advances by batch.
// - Skipped buffers are fully used beforehand.
// - No event index: used flags zero or one.
// - Event index: flags zero, kick threshold published.
//
// Decided for this implementation: the address map and strobed register access.
`default_nettype none
module sqcn_top
    import sqcn_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // Clock and reset
    input  wire logic              SYS_CLK,
    input  wire logic              RST_B,
    // Register port
    input  wire logic [7:0]        REG_ADDR,
    input  wire logic [DATA_W-1:0] REG_WDATA,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    output logic [DATA_W-1:0]      REG_RDATA,
    // Completions from the data path
    input  wire logic              COMP_VALID,
    output logic                   COMP_READY,
    input  wire logic [DATA_W-1:0] COMP_CHAIN_HEAD_REF,
    input  wire logic [DATA_W-1:0] COMP_LEN,
    input  wire logic [IDX_W-1:0]  COMP_BATCH,
    // Driver signalling
    input  wire logic              KICK_IN,
    output logic                   NOTIFY,
    // Guest memory bus
    output logic                   MEM_REQ,
    output logic                   MEM_WE,
    output logic [ADDR_W-1:0]      MEM_ADDR,
    output logic [DATA_W-1:0]      MEM_WDATA,
    output logic [BE_W-1:0]        MEM_BE,
    input  wire logic              MEM_GNT,
    input  wire logic              MEM_RVALID,
    input  wire logic [DATA_W-1:0] MEM_RDATA
);
    if (ADDR_W < 20 || ADDR_W > DATA_W) begin : g_chk
        $error("ADDR_W must lie between 20 and DATA_W");
    end

    typedef struct packed {
        sqcn_state_type    st;
        logic              issued;
        logic [CTRL_W-1:0] ctrl;
        logic [ADDR_W-1:0] used_base;
        logic [ADDR_W-1:0] avail_base;
        logic [IDX_W-1:0]  qsize;
        logic [IDX_W-1:0]  kick_thresh;
        logic [IDX_W-1:0]  used_idx;
        logic [DATA_W-1:0] head;
        logic [DATA_W-1:0] len;
        logic [IDX_W-1:0]  batch;
        logic [15:0]       drv_flags;
        logic [IDX_W-1:0]  drv_thresh;
        logic [DATA_W-1:0] notify_cnt;
        logic [DATA_W-1:0] kick_cnt;
        logic [2:0]        kick_sync;
        logic              comp_ready;
        logic              notify;
        logic [DATA_W-1:0] rdata;
        logic              start;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [BE_W-1:0]   be;
    } sqcn_core_type;

    sqcn_core_type s_r;
    sqcn_core_type s_nxt;

    sqcn_mem_if #(.ADDR_W(ADDR_W)) mem ();

    sqcn_mem_port #(.ADDR_W(ADDR_W)) u_port (
        .clk        (SYS_CLK),
        .rst_b      (RST_B),
        .req        (mem.port),
        .mem_req    (MEM_REQ),
        .mem_we     (MEM_WE),
        .mem_addr   (MEM_ADDR),
        .mem_wdata  (MEM_WDATA),
        .mem_be     (MEM_BE),
        .mem_gnt    (MEM_GNT),
        .mem_rvalid (MEM_RVALID),
        .mem_rdata  (MEM_RDATA)
    );

    // ----------------------------------------------------------------
    // Address arithmetic
    // ----------------------------------------------------------------
    logic [IDX_W-1:0]  slot;
    logic [ADDR_W-1:0] elem_addr;
    logic [ADDR_W-1:0] kthr_addr;
    logic [ADDR_W-1:0] uevt_addr;
    logic [IDX_W-1:0]  new_idx;
    logic [IDX_W-1:0]  evt_dist;
    logic [15:0]       used_flags;
    logic              evt_mode;
    logic              go;

    always_comb begin
        evt_mode  = s_r.ctrl[CTRL_EVT_BIT];
        slot      = s_r.used_idx & (s_r.qsize - 16'h0001);
        elem_addr = s_r.used_base + ADDR_W'(RING_OFS)
                  + (ADDR_W'(slot) << USED_ELEM_SH);
        kthr_addr = s_r.used_base + ADDR_W'(RING_OFS)
                  + (ADDR_W'(s_r.qsize) << USED_ELEM_SH);
        uevt_addr = s_r.avail_base + ADDR_W'(RING_OFS)
                  + (ADDR_W'(s_r.qsize) << AVAIL_ENT_SH);
        new_idx   = s_r.used_idx + s_r.batch;
        evt_dist  = s_r.drv_thresh - s_r.used_idx;
        used_flags = (!evt_mode && s_r.ctrl[CTRL_NOKICK_BIT])
                   ? FLAG_NO_NOTIFY : 16'h0000;
    end

    // ----------------------------------------------------------------
    // Engine, register port and kick counter
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt        = s_r;
        s_nxt.start  = 1'b0;
        s_nxt.notify = 1'b0;
        s_nxt.rdata  = '0;
        go           = 1'b0;
        s_nxt.kick_sync = {s_r.kick_sync[1:0], KICK_IN};
        if (s_r.kick_sync[1] && !s_r.kick_sync[2]) begin
            s_nxt.kick_cnt = s_r.kick_cnt + 32'h0000_0001;
        end

        if (REG_WR) begin
            unique case (REG_ADDR)
                REG_CTRL:        s_nxt.ctrl = REG_WDATA[CTRL_W-1:0];
                REG_USED_BASE:   s_nxt.used_base = REG_WDATA[ADDR_W-1:0];
                REG_AVAIL_BASE:  s_nxt.avail_base = REG_WDATA[ADDR_W-1:0];
                REG_QSIZE:       s_nxt.qsize = REG_WDATA[IDX_W-1:0];
                REG_KICK_THRESH: s_nxt.kick_thresh = REG_WDATA[IDX_W-1:0];
                default: ;
            endcase
        end
        if (REG_RD) begin
            unique case (REG_ADDR)
                REG_CTRL:        s_nxt.rdata = DATA_W'(s_r.ctrl);
                REG_USED_BASE:   s_nxt.rdata = DATA_W'(s_r.used_base);
                REG_AVAIL_BASE:  s_nxt.rdata = DATA_W'(s_r.avail_base);
                REG_QSIZE:       s_nxt.rdata = DATA_W'(s_r.qsize);
                REG_KICK_THRESH: s_nxt.rdata = DATA_W'(s_r.kick_thresh);
                REG_STATUS: begin
                    s_nxt.rdata = DATA_W'(s_r.used_idx);
                    s_nxt.rdata[STAT_BUSY_BIT] = (s_r.st != ST_IDLE);
                end
                REG_NOTIFY_CNT:  s_nxt.rdata = s_r.notify_cnt;
                REG_KICK_CNT:    s_nxt.rdata = s_r.kick_cnt;
                default:         s_nxt.rdata = '0;
            endcase
        end

        // A memory step is issued once, then waits for its answer.
        if (s_r.st != ST_IDLE && s_r.st != ST_DECIDE) begin
            if (!s_r.issued) begin
                s_nxt.issued = 1'b1;
                s_nxt.start  = 1'b1;
            end else if (mem.done) begin
                s_nxt.issued = 1'b0;
                go           = 1'b1;
            end
        end

        unique case (s_r.st)
            ST_IDLE: begin
                s_nxt.comp_ready = s_r.ctrl[CTRL_EN_BIT];
                if (COMP_VALID && s_r.comp_ready) begin
                    s_nxt.comp_ready = 1'b0;
                    s_nxt.head  = COMP_CHAIN_HEAD_REF;
                    s_nxt.len   = COMP_LEN;
                    s_nxt.batch = (s_r.ctrl[CTRL_INORD_BIT]
                                   && COMP_BATCH != 16'h0000)
                                ? COMP_BATCH : 16'h0001;
                    s_nxt.st    = ST_HEAD;
                    s_nxt.we    = 1'b1;
                    s_nxt.be    = BE_WORD;
                    s_nxt.addr  = elem_addr;
                    s_nxt.wdata = COMP_CHAIN_HEAD_REF;
                end
            end
            ST_HEAD: if (go) begin
                s_nxt.st    = ST_LEN;
                s_nxt.addr  = elem_addr + ADDR_W'(USED_LEN_OFS);
                s_nxt.wdata = s_r.len;
            end
            ST_LEN: if (go) begin
                if (evt_mode) begin
                    s_nxt.st    = ST_KTHR;
                    s_nxt.be    = BE_LOW;
                    s_nxt.addr  = kthr_addr;
                    s_nxt.wdata = DATA_W'(s_r.kick_thresh);
                end else begin
                    s_nxt.st    = ST_IDX;
                    s_nxt.addr  = s_r.used_base;
                    s_nxt.wdata = {new_idx, used_flags};
                end
            end
            ST_KTHR: if (go) begin
                s_nxt.st    = ST_IDX;
                s_nxt.be    = BE_WORD;
                s_nxt.addr  = s_r.used_base;
                s_nxt.wdata = {new_idx, used_flags};
            end
            ST_IDX: if (go) begin
                s_nxt.st   = ST_FLAGS;
                s_nxt.we   = 1'b0;
                s_nxt.addr = s_r.avail_base;
            end
            ST_FLAGS: if (go) begin
                s_nxt.drv_flags = mem.rdata[15:0];
                if (evt_mode) begin
                    s_nxt.st   = ST_UEVT;
                    s_nxt.addr = {uevt_addr[ADDR_W-1:2], 2'b00};
                end else begin
                    s_nxt.st   = ST_DECIDE;
                end
            end
            ST_UEVT: if (go) begin
                s_nxt.drv_thresh = uevt_addr[1] ? mem.rdata[31:16]
                                                : mem.rdata[15:0];
                s_nxt.st = ST_DECIDE;
            end
            ST_DECIDE: begin
                if (evt_mode) begin
                    s_nxt.notify = (evt_dist < s_r.batch);
                end else begin
                    s_nxt.notify = (s_r.drv_flags == 16'h0000);
                end
                if (s_nxt.notify) begin
                    s_nxt.notify_cnt = s_r.notify_cnt + 32'h0000_0001;
                end
                s_nxt.used_idx   = new_idx;
                s_nxt.comp_ready = s_r.ctrl[CTRL_EN_BIT];
                s_nxt.st         = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            s_r       <= '0;
            s_r.st    <= ST_IDLE;
            s_r.ctrl  <= CTRL_RST;
            s_r.qsize <= QSIZE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign mem.start  = s_r.start;
    assign mem.we     = s_r.we;
    assign mem.addr   = s_r.addr;
    assign mem.wdata  = s_r.wdata;
    assign mem.be     = s_r.be;
    assign REG_RDATA  = s_r.rdata;
    assign COMP_READY = s_r.comp_ready;
    assign NOTIFY     = s_r.notify;
endmodule
`default_nettype wire

/* File: test/sqcn_chk.sv */
// Checker for used-ring write order and notification timing.
`default_nettype none
module sqcn_chk
    import sqcn_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // Clock and reset
    input wire logic              SYS_CLK,
    input wire logic              RST_B,
    // Register port
    input wire logic [7:0]        REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic              REG_WR,
    // Completions and signalling
    input wire logic              COMP_VALID,
    input wire logic              COMP_READY,
    input wire logic [DATA_W-1:0] COMP_CHAIN_HEAD_REF,
    input wire logic [DATA_W-1:0] COMP_LEN,
    input wire logic [IDX_W-1:0]  COMP_BATCH,
    input wire logic              NOTIFY,
    // Guest memory bus
    input wire logic              MEM_REQ,
    input wire logic              MEM_WE,
    input wire logic [ADDR_W-1:0] MEM_ADDR,
    input wire logic [DATA_W-1:0] MEM_WDATA,
    input wire logic              MEM_GNT
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [ADDR_W-1:0] ubase_r;
    logic [DATA_W-1:0] head_r, len_r;
    logic [IDX_W-1:0]  bat_r, uidx_r;
    logic [2:0]        wcnt_r;
    logic              evt_r, inord_r;
    wire take = COMP_VALID && COMP_READY;
    wire wr_go = MEM_REQ && MEM_WE && MEM_GNT;
    wire idx_wr = MEM_REQ && MEM_WE && MEM_ADDR == ubase_r;
    wire [IDX_W-1:0] bat = (!inord_r || COMP_BATCH == 16'h0)
                           ? 16'h0001 : COMP_BATCH;
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ubase_r <= '0;
            {head_r, len_r, bat_r, uidx_r, wcnt_r} <= '0;
            {evt_r, inord_r} <= 2'h0;
        end else begin
            if (REG_WR && REG_ADDR == REG_USED_BASE)
                ubase_r <= REG_WDATA[ADDR_W-1:0];
            if (REG_WR && REG_ADDR == REG_CTRL)
                {inord_r, evt_r} <= REG_WDATA[CTRL_INORD_BIT -: 2];
            if (take) begin
                {head_r, len_r} <= {COMP_CHAIN_HEAD_REF, COMP_LEN};
                bat_r <= bat;
                wcnt_r <= 3'h0;
            end else if (wr_go)
                wcnt_r <= wcnt_r + 3'h1;
            if (wr_go && idx_wr)
                uidx_r <= uidx_r + bat_r;
        end
    end
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);
    chk_req_hold:
    assert property (MEM_REQ && !MEM_GNT |=> MEM_REQ && $stable(MEM_ADDR)
        && $stable(MEM_WDATA)) else $error("request moved");
    chk_idle_quiet:
    assert property (COMP_READY |-> !MEM_REQ)
        else $error("access while idle");
    chk_take_drop:
    assert property (take |=> !COMP_READY)
        else $error("ready held");
    chk_head_data:
    assert property (wr_go && wcnt_r == 3'h0 |-> MEM_WDATA == head_r)
        else $error("bad head write");
    chk_len_data:
    assert property (wr_go && wcnt_r == 3'h1 |-> MEM_WDATA == len_r)
        else $error("bad length write");
    chk_idx_order:
    assert property (idx_wr |-> wcnt_r >= (evt_r ? 3'h3 : 3'h2))
        else $error("index too early");
    chk_idx_value:
    assert property (idx_wr |-> MEM_WDATA[31:16] == uidx_r + bat_r)
        else $error("bad index step");
    chk_flags_legal:
    assert property (idx_wr |-> MEM_WDATA[15:1] == 15'h0
        && !(evt_r && MEM_WDATA[0])) else $error("bad used flags");
    chk_notify_once:
    assert property (NOTIFY |=> !NOTIFY) else $error("notify too long");
    chk_notify_end:
    assert property (NOTIFY |-> $rose(COMP_READY))
        else $error("stray notify");
    cov_take: cover property (take);
    cov_notify: cover property (NOTIFY);
    cov_batch: cover property (idx_wr && bat_r > 16'h0001);
endmodule
bind sqcn_top sqcn_chk #(.ADDR_W(ADDR_W)) u_chk (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .COMP_VALID(COMP_VALID),
    .COMP_READY(COMP_READY), .COMP_CHAIN_HEAD_REF(COMP_CHAIN_HEAD_REF),
    .COMP_LEN(COMP_LEN), .COMP_BATCH(COMP_BATCH), .NOTIFY(NOTIFY),
    .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .MEM_GNT(MEM_GNT)
);
`default_nettype wire

/* File: test/sqcn_mem_model.sv */
// Guest memory holding both rings, granting promptly or slowly.
`default_nettype none
module sqcn_mem_model
    import sqcn_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // Clock, reset and pace
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              slow,
    // Memory bus
    input  wire logic              req,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [BE_W-1:0]   be,
    output logic                   gnt,
    output logic                   rvalid,
    output logic [DATA_W-1:0]      rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] m [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] rd_q, nw;
    logic [1:0]        wait_r;
    logic              rd_pend;
    function automatic logic [DATA_W-1:0] peek(input logic [ADDR_W-1:0] a);
        return m.exists(a) ? m[a] : '0;
    endfunction
    function automatic void poke(input logic [ADDR_W-1:0] a,
                                 input logic [DATA_W-1:0] d);
        m[a] = d;
    endfunction
    // Idle read data toggles so a late sample never looks valid.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {gnt, rvalid, rd_pend, wait_r} <= '0;
            rdata <= '0;
        end else begin
            gnt <= 1'b0;
            rvalid <= rd_pend;
            rdata <= rd_pend ? rd_q : ~rdata;
            rd_pend <= 1'b0;
            if (req && !gnt) begin
                if (!slow || wait_r == 2'h3) begin
                    gnt <= 1'b1;
                    wait_r <= 2'h0;
                    rd_pend <= !we;
                    rd_q <= peek(addr);
                    nw = peek(addr);
                    for (int i = 0; i < BE_W; i++)
                        if (be[i] && we) nw[8*i +: 8] = wdata[8*i +: 8];
                    m[addr] = nw;
                end else
                    wait_r <= wait_r + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the split queue completion notifier.
`default_nettype none
module tb
    import sqcn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] UB = 32'h0000_1000;
    localparam logic [31:0] AB = 32'h0000_2000;
    localparam int          QS = 4;
    logic              SYS_CLK, RST_B, REG_WR, REG_RD, COMP_VALID, KICK_IN;
    logic [7:0]        REG_ADDR;
    logic [DATA_W-1:0] REG_WDATA, REG_RDATA, COMP_CHAIN_HEAD_REF, COMP_LEN;
    logic [IDX_W-1:0]  COMP_BATCH;
    logic              COMP_READY, NOTIFY, MEM_REQ, MEM_WE, MEM_GNT;
    logic              MEM_RVALID, slow;
    logic [31:0]       MEM_ADDR, rv;
    logic [DATA_W-1:0] MEM_WDATA, MEM_RDATA;
    logic [BE_W-1:0]   MEM_BE;
    logic [3:0]        ctl;
    logic [15:0]       exp_idx;
    int                err_total, n_checks, n_notes;
    sqcn_top DUT (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .COMP_VALID(COMP_VALID),
        .COMP_READY(COMP_READY), .COMP_CHAIN_HEAD_REF(COMP_CHAIN_HEAD_REF),
        .COMP_LEN(COMP_LEN), .COMP_BATCH(COMP_BATCH), .KICK_IN(KICK_IN),
        .NOTIFY(NOTIFY), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
        .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_BE(MEM_BE),
        .MEM_GNT(MEM_GNT), .MEM_RVALID(MEM_RVALID), .MEM_RDATA(MEM_RDATA));
    sqcn_mem_model u_mem (.clk(SYS_CLK), .rst_b(RST_B), .slow(slow),
        .req(MEM_REQ), .we(MEM_WE), .addr(MEM_ADDR), .wdata(MEM_WDATA),
        .be(MEM_BE), .gnt(MEM_GNT), .rvalid(MEM_RVALID), .rdata(MEM_RDATA));
    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        @(negedge SYS_CLK);
        d = REG_RDATA;
    endtask
    task automatic set_ctl(input logic [3:0] v);
        ctl = v;
        wr(REG_CTRL, {28'h0, v});
    endtask
    task automatic hint(input logic [15:0] fl, input logic [15:0] ue);
        u_mem.poke(AB, {16'h0, fl});
        u_mem.poke(AB + 32'h0C, {16'h0, ue});
    endtask
    // The expected notification follows the driver hints in memory.
    task automatic comp(input logic [31:0] hd, input logic [15:0] bt);
        int          k, n;
        logic [15:0] old, ue, fl, bat;
        logic        en;
        n = 0;
        old = exp_idx;
        bat = (!ctl[CTRL_INORD_BIT] || bt == 16'h0) ? 16'h1 : bt;
        ue = 16'(u_mem.peek(AB + 32'h0C));
        fl = 16'(u_mem.peek(AB));
        en = ctl[CTRL_EVT_BIT] ? (16'(ue - old) < bat) : (fl == 16'h0);
        for (k = 0; k < 300 && COMP_READY !== 1'b1; k++) @(negedge SYS_CLK);
        @(posedge SYS_CLK);
        COMP_VALID <= 1'b1;
        COMP_CHAIN_HEAD_REF <= hd;
        COMP_LEN <= ~hd;
        COMP_BATCH <= bt;
        @(posedge SYS_CLK);
        COMP_VALID <= 1'b0;
        repeat (2) @(negedge SYS_CLK);
        for (; k < 300 && COMP_READY !== 1'b1; k++) begin
            @(negedge SYS_CLK);
            n += int'(NOTIFY === 1'b1);
        end
        @(negedge SYS_CLK);
        n += int'(NOTIFY === 1'b1);
        if (k >= 300) begin
            err_total++;
            test_done();
        end
        exp_idx = old + bat;
        n_notes += int'(en);
        chk(u_mem.peek(UB + 32'(4 + 8 * (old % QS))), hd);
        chk(u_mem.peek(UB + 32'(8 + 8 * (old % QS))), ~hd);
        chk(u_mem.peek(UB), {exp_idx, 15'h0, ctl[3] & ~ctl[1]});
        chk(32'(n), 32'(en));
    endtask
    initial begin
        {RST_B, REG_WR, REG_RD, COMP_VALID, KICK_IN, slow, ctl} = '0;
        {REG_ADDR, REG_WDATA, COMP_CHAIN_HEAD_REF, COMP_LEN, COMP_BATCH} = '0;
        {err_total, n_checks, n_notes, exp_idx} = '0;
        repeat (6) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        rd(REG_CTRL, rv); chk(rv, 32'h0);
        rd(REG_QSIZE, rv); chk(rv, {16'h0, QSIZE_RST});
        rd(REG_STATUS, rv); chk(rv, 32'h0);
        rd(8'hFC, rv); chk(rv, 32'h0);
        wr(REG_USED_BASE, UB);
        wr(REG_AVAIL_BASE, AB);
        wr(REG_QSIZE, 32'(QS));
        wr(REG_KICK_THRESH, 32'h0000_0005);
        u_mem.poke(UB, 32'h0);
        set_ctl(4'h1);
        hint(16'h0, 16'h7);
        comp(32'h0000_0011, 16'h0);
        hint(16'h1, exp_idx);
        comp(32'h0000_0012, 16'h0);
        slow = 1'b1;
        set_ctl(4'h9);
        hint(16'h0, 16'h0);
        repeat (3) comp(32'h0000_0013, 16'h0);
        set_ctl(4'hB);
        hint(16'h1, exp_idx);
        comp(32'h0000_0021, 16'h0);
        comp(32'h0000_0022, 16'h0);
        chk(u_mem.peek(UB + 32'(4 + 8 * QS)) & 32'hFFFF, 32'h5);
        slow = 1'b0;
        set_ctl(4'h5);
        hint(16'h0, 16'h0);
        comp(32'h0000_0031, 16'h3);
        comp(32'h0000_0032, 16'hFFFF);
        set_ctl(4'h7);
        hint(16'h0, exp_idx + 16'h1);
        comp(32'h0000_0033, 16'h2);
        set_ctl(4'h9);
        repeat (6) begin
            @(posedge SYS_CLK) KICK_IN <= ~KICK_IN;
            repeat (2) @(posedge SYS_CLK);
        end
        rd(REG_KICK_CNT, rv); chk(rv, 32'h3);
        rd(REG_NOTIFY_CNT, rv); chk(rv, 32'(n_notes));
        wr(REG_STATUS, 32'hFFFF_FFFF);
        rd(REG_STATUS, rv); chk(rv, {16'h0, exp_idx});
        RST_B = 1'b0;
        repeat (6) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        rd(REG_STATUS, rv); chk(rv, 32'h0);
        rd(REG_CTRL, rv); chk(rv, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
